//--- src/psurb_pkg.sv
// Purpose: Shared constants of the proximity upper register bank
// Assumes: Byte wide registers at their printed offsets
// Notes: Offsets live here; the top also uses literal field bit ranges and reset values
package psurb_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h0F;
  localparam logic [7:0] ADDR_REV = 8'h11;
  localparam logic [7:0] ADDR_PART = 8'h12;
  localparam logic [7:0] ADDR_STAT = 8'h13;
  localparam logic [7:0] ADDR_RES_LO = 8'h18;
  localparam logic [7:0] ADDR_RES_HI = 8'h19;
  localparam logic [7:0] ADDR_OFFS = 8'h1E;
  localparam int CTRL_DRIVE_LSB = 6;
  localparam int CTRL_DIODE_LSB = 4;
  localparam int CTRL_GAIN_LSB = 2;
  localparam int REV_STEP_W = 4;
  localparam int STAT_SAT_BIT = 6;
  localparam int STAT_IRQ_BIT = 5;
  localparam int STAT_VALID_BIT = 1;
  localparam int OFFS_SIGN_BIT = 7;
  localparam int OFFS_MAG_W = 7;
  localparam int RES_W = 16;
  localparam int SHIFT_W = 19;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] OFFS_RESET = 8'h00;
  localparam logic [1:0] DIODE_NONE = 2'h0;
  localparam logic [1:0] DIODE_RESERVED = 2'h3;
  localparam logic [2:0] LOW_RANGE_SHIFT = 3'h3;
endpackage

//--- src/psurb_sync.sv
// Purpose: Two flip-flop level synchroniser
// Assumes: Synchronous active low reset in the destination domain
// Notes: The first stage feeds only the second stage
`timescale 1ns/1ns
module psurb_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d_in;
    q_nxt = meta_r;
    if (!rst_n_in) begin
      meta_nxt = '0;
      q_nxt = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    meta_r <= meta_nxt;
    q_out <= q_nxt;
  end
endmodule

//--- src/psurb_xfer.sv
// Purpose: Word crossing by toggle handshake, mirroring a value
// Assumes: Source value may change at any time; latest one wins
// Notes: Held word stays stable while its toggle is in flight
`timescale 1ns/1ns
module psurb_xfer #(
  parameter int W = 8
) (
  input wire logic src_clk_in,
  input wire logic src_rst_n_in,
  input wire logic [W-1:0] src_data_in,
  input wire logic dst_clk_in,
  input wire logic dst_rst_n_in,
  output logic [W-1:0] dst_data_out
);
  logic req_r;
  logic req_nxt;
  logic [W-1:0] hold_r;
  logic [W-1:0] hold_nxt;
  logic ack_s;
  logic req_s;
  logic seen_r;
  logic seen_nxt;
  logic [W-1:0] data_nxt;

  psurb_sync #(.W(1)) u_ack (
    .clk_in(src_clk_in),
    .rst_n_in(src_rst_n_in),
    .d_in(seen_r),
    .q_out(ack_s)
  );

  psurb_sync #(.W(1)) u_req (
    .clk_in(dst_clk_in),
    .rst_n_in(dst_rst_n_in),
    .d_in(req_r),
    .q_out(req_s)
  );

  always_comb begin
    req_nxt = req_r;
    hold_nxt = hold_r;
    if (ack_s == req_r) begin
      hold_nxt = src_data_in;
      req_nxt = ~req_r;
    end
    if (!src_rst_n_in) begin
      req_nxt = 1'b0;
      hold_nxt = '0;
    end
  end

  always_ff @(posedge src_clk_in) begin
    req_r <= req_nxt;
    hold_r <= hold_nxt;
  end

  always_comb begin
    seen_nxt = seen_r;
    data_nxt = dst_data_out;
    if (req_s != seen_r) begin
      seen_nxt = req_s;
      data_nxt = hold_r;
    end
    if (!dst_rst_n_in) begin
      seen_nxt = 1'b0;
      data_nxt = '0;
    end
  end

  always_ff @(posedge dst_clk_in) begin
    seen_r <= seen_nxt;
    dst_data_out <= data_nxt;
  end
endmodule

//--- src/psurb_top.sv
// Purpose: Upper register bank of a proximity detector
// Assumes: Host access port runs on link_clk_in, measurement on clock_in
// Notes: Registers live on the link side; analog settings cross to core
//
// Notes on behaviour
// - LED drive from bits 7:6, low range divides
// - Bits 5:4 pick none, first or second diode
// - Gain from bits 3:2; bits 1:0 reserved
// - Revision reads step in 3:0, zeros above
// - Part register returns fixed part number code
// - Status register is read only device state
// - Bit 6 set on saturated measurement
// - Bit 5 mirrors active proximity interrupt
// - Bit 1 set after cycle begun while enabled
// - Status bits 4:2 always read zero
// - Result held as 16 bits at 0x18, 0x19
// - Low read latches high byte for next read
// - Offset is sign magnitude, bit 7 positive
// - Offset register is zero after reset
// - Offset shift scales with gain, drive, pulses
// - Proximity enable gates the begun cycle and the valid flag
// - Pulse count sets LED pulses per measurement
`timescale 1ns/1ns
module psurb_top
  import psurb_pkg::*;
#(
  parameter logic [3:0] SILICON_STEP = 4'h1,
  parameter logic [7:0] PART_CODE = 8'h5A
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  input wire logic [7:0] acc_addr_in,
  input wire logic acc_wr_in,
  input wire logic acc_rd_in,
  input wire logic [7:0] acc_wdata_in,
  output logic [7:0] acc_rdata_out,
  output logic acc_rvalid_out,
  input wire logic prox_function_enable_in,
  input wire logic [7:0] led_pulse_count_in,
  input wire logic low_drive_range_in,
  input wire logic meas_start_in,
  input wire logic meas_done_in,
  input wire logic meas_saturated_in,
  input wire logic [RES_W-1:0] meas_result_in,
  input wire logic prox_irq_in,
  output logic [1:0] led_drive_strength_out,
  output logic [1:0] photodiode_select_out,
  output logic [1:0] prox_gain_setting_out,
  output logic [SHIFT_W-1:0] offset_shift_out
);
  // SILICON_STEP and PART_CODE defaults are arbitrary values

  ////////////////////////////////////////////////////////////////////
  // Link reset and crossings
  logic link_rst_n;
  logic [RES_W+2:0] stat_word;
  logic [RES_W+2:0] stat_mirror;
  logic [13:0] ctrl_word;
  logic [13:0] ctrl_mirror;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] offs_r;
  logic [7:0] offs_nxt;
  logic [7:0] shadow_r;
  logic [7:0] shadow_nxt;
  logic [7:0] rdata_nxt;
  logic rvalid_nxt;
  logic [7:0] stat_byte;
  logic sat_r;
  logic sat_nxt;
  logic irq_r;
  logic irq_nxt;
  logic valid_r;
  logic valid_nxt;
  logic began_r;
  logic began_nxt;
  logic [RES_W-1:0] res_r;
  logic [RES_W-1:0] res_nxt;
  logic [1:0] drive_nxt;
  logic [1:0] diode_nxt;
  logic [1:0] gain_nxt;
  logic [SHIFT_W-1:0] shift_nxt;
  logic [SHIFT_W-1:0] mag_scaled;
  logic [3:0] att;

  // Reset release reaches the link side two link edges late
  psurb_sync #(.W(1)) u_link_rst (
    .clk_in(link_clk_in),
    .rst_n_in(1'b1),
    .d_in(rst_n_in),
    .q_out(link_rst_n)
  );

  assign stat_word = {sat_r, irq_r, valid_r, res_r};
  assign ctrl_word = {ctrl_r[7:2], offs_r};

  psurb_xfer #(.W(RES_W + 3)) u_stat_xfer (
    .src_clk_in(clock_in),
    .src_rst_n_in(rst_n_in),
    .src_data_in(stat_word),
    .dst_clk_in(link_clk_in),
    .dst_rst_n_in(link_rst_n),
    .dst_data_out(stat_mirror)
  );

  psurb_xfer #(.W(14)) u_ctrl_xfer (
    .src_clk_in(link_clk_in),
    .src_rst_n_in(link_rst_n),
    .src_data_in(ctrl_word),
    .dst_clk_in(clock_in),
    .dst_rst_n_in(rst_n_in),
    .dst_data_out(ctrl_mirror)
  );

  ////////////////////////////////////////////////////////////////////
  // Link side register file
  always_comb begin
    stat_byte = 8'h00;
    stat_byte[STAT_SAT_BIT] = stat_mirror[RES_W+2];
    stat_byte[STAT_IRQ_BIT] = stat_mirror[RES_W+1];
    stat_byte[STAT_VALID_BIT] = stat_mirror[RES_W];
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    offs_nxt = offs_r;
    shadow_nxt = shadow_r;
    rdata_nxt = acc_rdata_out;
    rvalid_nxt = acc_rd_in;
    // Only the two writable registers take host data
    if (acc_wr_in) begin
      case (acc_addr_in)
        ADDR_CTRL: ctrl_nxt = {acc_wdata_in[7:2], 2'b00};
        ADDR_OFFS: offs_nxt = acc_wdata_in;
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    if (acc_rd_in) begin
      case (acc_addr_in)
        ADDR_CTRL: rdata_nxt = ctrl_r;
        ADDR_REV: rdata_nxt = {{(8 - REV_STEP_W){1'b0}}, SILICON_STEP};
        ADDR_PART: rdata_nxt = PART_CODE;
        ADDR_STAT: rdata_nxt = stat_byte;
        ADDR_RES_LO: begin
          rdata_nxt = stat_mirror[7:0];
          shadow_nxt = stat_mirror[RES_W-1:8];
        end
        // Stale unless a low read came first, hence the burst advice
        ADDR_RES_HI: rdata_nxt = shadow_r;
        ADDR_OFFS: rdata_nxt = offs_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
    if (!link_rst_n) begin
      ctrl_nxt = CTRL_RESET;
      offs_nxt = OFFS_RESET;
      shadow_nxt = 8'h00;
      rdata_nxt = 8'h00;
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge link_clk_in) begin
    ctrl_r <= ctrl_nxt;
    offs_r <= offs_nxt;
    shadow_r <= shadow_nxt;
    acc_rdata_out <= rdata_nxt;
    acc_rvalid_out <= rvalid_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // Core side status capture
  always_comb begin
    sat_nxt = sat_r;
    valid_nxt = valid_r;
    began_nxt = began_r;
    res_nxt = res_r;
    irq_nxt = prox_irq_in;
    if (meas_start_in && prox_function_enable_in) begin
      began_nxt = 1'b1;
    end
    if (meas_done_in) begin
      res_nxt = meas_result_in;
      sat_nxt = meas_saturated_in;
      if (began_r && prox_function_enable_in) begin
        valid_nxt = 1'b1;
      end
    end
    // Disabling clears begun and valid; result and saturation still captured
    if (!prox_function_enable_in) begin
      valid_nxt = 1'b0;
      began_nxt = 1'b0;
    end
    if (!rst_n_in) begin
      sat_nxt = 1'b0;
      irq_nxt = 1'b0;
      valid_nxt = 1'b0;
      began_nxt = 1'b0;
      res_nxt = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    sat_r <= sat_nxt;
    irq_r <= irq_nxt;
    valid_r <= valid_nxt;
    began_r <= began_nxt;
    res_r <= res_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // Core side analog settings and offset scaling
  always_comb begin
    drive_nxt = ctrl_mirror[13:12];
    diode_nxt = ctrl_mirror[11:10];
    // Reserved diode code is parked on no diode rather than passed on
    if (diode_nxt == DIODE_RESERVED) begin
      diode_nxt = DIODE_NONE;
    end
    gain_nxt = ctrl_mirror[9:8];
    // Each drive step halves current; low range divides further
    att = {2'b00, drive_nxt} + (low_drive_range_in ? {1'b0, LOW_RANGE_SHIFT} : 4'h0);
    mag_scaled = SHIFT_W'(ctrl_mirror[OFFS_MAG_W-1:0]) * SHIFT_W'(led_pulse_count_in);
    mag_scaled = SHIFT_W'((mag_scaled << gain_nxt) >> att);
    shift_nxt = ctrl_mirror[OFFS_SIGN_BIT] ? mag_scaled : SHIFT_W'(-mag_scaled);
    if (!rst_n_in) begin
      drive_nxt = 2'h0;
      diode_nxt = 2'h0;
      gain_nxt = 2'h0;
      shift_nxt = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    led_drive_strength_out <= drive_nxt;
    photodiode_select_out <= diode_nxt;
    prox_gain_setting_out <= gain_nxt;
    offset_shift_out <= shift_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  revision_read_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
    acc_rd_in && acc_addr_in == ADDR_REV |=> acc_rvalid_out && acc_rdata_out == {4'h0, SILICON_STEP})
    else $error("revision read wrong");

  part_code_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
    acc_rd_in && acc_addr_in == ADDR_PART |=> acc_rdata_out == PART_CODE)
    else $error("part code read wrong");

  status_zero_bits_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
    acc_rd_in && acc_addr_in == ADDR_STAT |=> acc_rdata_out[4:2] == 3'b000)
    else $error("status reserved bits not zero");

  shadow_latch_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
    acc_rd_in && acc_addr_in == ADDR_RES_LO ##1 acc_rd_in && acc_addr_in == ADDR_RES_HI
    |=> acc_rdata_out == $past(stat_mirror[RES_W-1:8], 2))
    else $error("high byte not paired with low read");

  ro_write_ignored_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
    acc_wr_in && acc_addr_in != ADDR_CTRL && acc_addr_in != ADDR_OFFS |=> $stable(ctrl_r) && $stable(offs_r))
    else $error("read only write changed state");

  offset_reset_a: assert property (@(posedge link_clk_in)
    !link_rst_n |=> offs_r == 8'h00)
    else $error("offset not zero after reset");

  sat_flag_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    meas_done_in && meas_saturated_in |=> sat_r ##1 stat_word[RES_W+2])
    else $error("saturation not flagged");

  irq_follow_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ##1 irq_r == $past(prox_irq_in))
    else $error("interrupt status not following");

  valid_gate_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !prox_function_enable_in |=> !valid_r)
    else $error("valid set while disabled");

  diode_safe_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    photodiode_select_out != DIODE_RESERVED)
    else $error("reserved diode code driven");

  ctrl_write_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
    acc_wr_in && acc_addr_in == ADDR_CTRL |=> ctrl_r == {$past(acc_wdata_in[7:2]), 2'b00})
    else $error("control write not stored");

  offset_write_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
    acc_wr_in && acc_addr_in == ADDR_OFFS |=> offs_r == $past(acc_wdata_in))
    else $error("offset write not stored");

  result_low_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
    acc_rd_in && acc_addr_in == ADDR_RES_LO |=> acc_rdata_out == $past(stat_mirror[7:0]))
    else $error("low result byte wrong");

  status_read_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
    acc_rd_in && acc_addr_in == ADDR_STAT |=> acc_rdata_out[STAT_SAT_BIT] == $past(stat_mirror[RES_W+2])
    && acc_rdata_out[STAT_VALID_BIT] == $past(stat_mirror[RES_W]))
    else $error("status read wrong");

  result_capture_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    meas_done_in |=> res_r == $past(meas_result_in))
    else $error("result not captured");

  sat_clear_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    meas_done_in && !meas_saturated_in |=> !sat_r)
    else $error("saturation kept after clean measurement");

  valid_set_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    meas_done_in && began_r && prox_function_enable_in |=> valid_r)
    else $error("valid not set after cycle");

  valid_start_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $rose(valid_r) |-> $past(began_r))
    else $error("valid without a begun cycle");

  drive_follow_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    1'b1 |=> led_drive_strength_out == $past(ctrl_mirror[13:12]))
    else $error("drive strength not following");

  gain_follow_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    1'b1 |=> prox_gain_setting_out == $past(ctrl_mirror[9:8]))
    else $error("gain not following");

  diode_follow_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ctrl_mirror[11:10] != DIODE_RESERVED |=> photodiode_select_out == $past(ctrl_mirror[11:10]))
    else $error("diode select not following");

  pair_read_c: cover property (@(posedge link_clk_in) disable iff (!link_rst_n)
    acc_rd_in && acc_addr_in == ADDR_RES_LO ##1 acc_rd_in && acc_addr_in == ADDR_RES_HI);

  sat_meas_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    meas_done_in && meas_saturated_in);

  valid_set_c: cover property (@(posedge clock_in) disable iff (!rst_n_in) $rose(valid_r));

  irq_seen_c: cover property (@(posedge clock_in) disable iff (!rst_n_in) $rose(irq_r));

  offs_write_c: cover property (@(posedge link_clk_in) disable iff (!link_rst_n)
    acc_wr_in && acc_addr_in == ADDR_OFFS);
endmodule

//--- bench/psurb_host.sv
// Purpose: Host model driving the register port on the link clock
// Assumes: One strobe per request, answer about one link cycle later
// Notes: A released write address shows its inverse; a released read address flips each cycle, ending on the last value
`timescale 1ns/1ns
module psurb_host (
  input wire logic link_clk_in,
  input wire logic [7:0] acc_rdata_in,
  input wire logic acc_rvalid_in,
  output logic [7:0] acc_addr_out,
  output logic acc_wr_out,
  output logic acc_rd_out,
  output logic [7:0] acc_wdata_out
);
  initial begin
    acc_addr_out = 8'h00;
    acc_wr_out = 1'b0;
    acc_rd_out = 1'b0;
    acc_wdata_out = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge link_clk_in);
    acc_addr_out = a;
    acc_wdata_out = d;
    acc_wr_out = 1'b1;
    @(negedge link_clk_in);
    acc_wr_out = 1'b0;
    acc_addr_out = ~a;
    acc_wdata_out = ~d;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Back to back reads of n bytes from a upward; the result pair goes as one
  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] q [2]);
    int got;
    got = 0;
    for (int i = 0; i < n + 4; i++) begin
      @(negedge link_clk_in);
      if (acc_rvalid_in === 1'b1 && got < 2) begin
        q[got] = acc_rdata_in;
        got++;
      end
      acc_rd_out = (i < n);
      acc_addr_out = (i < n) ? a + i[7:0] : ~acc_addr_out;
    end
  endtask
endmodule

//--- bench/psurb_tb_top.sv
// Purpose: Self-checking bench of the upper register bank
// Assumes: Host model on the link clock, core inputs driven here
// Notes: Reset is held long enough for four link edges as well
`timescale 1ns/1ns
module psurb_tb_top;
  import psurb_pkg::*;
  localparam logic [3:0] STEP = 4'hC; // Arbitrary value
  localparam logic [7:0] PART = 8'hA7; // Arbitrary value
  logic clock_in = 1'b0;
  logic link_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr, wdata, rdata, pulses;
  logic wr, rd, rvalid;
  logic en = 1'b0, low = 1'b0, start = 1'b0, done = 1'b0, sat = 1'b0, irq = 1'b0;
  logic [15:0] result = 16'h0000;
  logic [1:0] drive, diode, gain;
  logic [SHIFT_W-1:0] shift;
  int n_mismatch = 0;
  int n_tests = 0;
  initial pulses = 8'h00;
  always #5 clock_in = ~clock_in;
  // Odd phase and 15 ns period keep the link rising edges apart from the core edges
  initial begin
    #3;
    forever begin
      link_clk_in = ~link_clk_in;
      #7;
      link_clk_in = ~link_clk_in;
      #8;
    end
  end
  psurb_top #(.SILICON_STEP(STEP), .PART_CODE(PART)) dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
    .acc_addr_in(addr), .acc_wr_in(wr), .acc_rd_in(rd), .acc_wdata_in(wdata),
    .acc_rdata_out(rdata), .acc_rvalid_out(rvalid),
    .prox_function_enable_in(en), .led_pulse_count_in(pulses), .low_drive_range_in(low),
    .meas_start_in(start), .meas_done_in(done), .meas_saturated_in(sat),
    .meas_result_in(result), .prox_irq_in(irq),
    .led_drive_strength_out(drive), .photodiode_select_out(diode),
    .prox_gain_setting_out(gain), .offset_shift_out(shift));
  psurb_host host (.link_clk_in(link_clk_in), .acc_rdata_in(rdata), .acc_rvalid_in(rvalid),
    .acc_addr_out(addr), .acc_wr_out(wr), .acc_rd_out(rd), .acc_wdata_out(wdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [18:0] seen, input logic [18:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic cw(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic rr(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] q [2];
    host.rd(a, 1, q);
    chk(q[0], exp, msg);
  endtask
  task automatic pr(input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] q [2];
    host.rd(ADDR_RES_LO, 2, q);
    chk(q[0], lo, "result low");
    chk(q[1], hi, "result high");
  endtask
  task automatic meas(input logic [15:0] r, input logic s);
    @(negedge clock_in);
    start = 1'b1;
    @(negedge clock_in);
    start = 1'b0;
    cw(2);
    done = 1'b1;
    result = r;
    sat = s;
    @(negedge clock_in);
    done = 1'b0;
    result = ~r;
    repeat (12) @(negedge link_clk_in);
  endtask
  // Own model of the offset shift, kept apart from the design's arithmetic
  function automatic logic [18:0] shift_exp(logic [7:0] o, logic [7:0] c, logic [7:0] p, logic l);
    logic [18:0] m;
    m = ((19'(o[6:0]) * 19'(p)) << c[3:2]) >> (c[7:6] + 3 * l);
    return o[7] ? m : -m;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rr(ADDR_CTRL, 8'h00, "ctrl after reset");
    rr(ADDR_OFFS, 8'h00, "offset after reset");
    chk(shift, 19'h00000, "shift after reset");
    $display("test reset done");
  endtask
  task automatic t_ident();
    rr(ADDR_REV, {4'h0, STEP}, "revision");
    rr(ADDR_PART, PART, "part code");
    host.wr(ADDR_REV, 8'hFF);
    host.wr(ADDR_PART, 8'h00);
    rr(ADDR_REV, {4'h0, STEP}, "revision kept");
    rr(ADDR_PART, PART, "part code kept");
    rr(8'h20, 8'h00, "unmapped");
    $display("test ident done");
  endtask
  task automatic t_ctrl();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], (i == 3) ? 2'h2 : i[1:0], ~i[1:0], 2'h3};
      host.wr(ADDR_CTRL, v);
      rr(ADDR_CTRL, v & 8'hFC, "ctrl readback");
      cw(12);
      chk(drive, i[1:0], "drive");
      chk(diode, (i == 3) ? 2'h2 : i[1:0], "diode");
      chk(gain, 2'(~i[1:0]), "gain");
    end
    $display("test ctrl done");
  endtask
  task automatic off_case(input logic [7:0] c, input logic [7:0] o, input logic [7:0] p, input logic l);
    host.wr(ADDR_CTRL, c);
    host.wr(ADDR_OFFS, o);
    @(negedge clock_in);
    pulses = p;
    low = l;
    cw(12);
    chk(shift, shift_exp(o, c, p, l), "offset shift");
    rr(ADDR_OFFS, o, "offset readback");
  endtask
  task automatic t_offset();
    off_case(8'h0C, 8'hFF, 8'hFF, 1'b0);
    off_case(8'h84, 8'h25, 8'h10, 1'b1);
    $display("test offset done");
  endtask
  task automatic t_meas();
    meas(16'h1111, 1'b0);
    rr(ADDR_STAT, 8'h00, "valid while disabled");
    @(negedge clock_in);
    en = 1'b1;
    irq = 1'b1;
    meas(16'hA55A, 1'b1);
    rr(ADDR_STAT, 8'h62, "status sat irq valid");
    host.wr(ADDR_STAT, 8'hFF);
    host.wr(ADDR_RES_LO, 8'hFF);
    host.wr(ADDR_RES_HI, 8'hFF);
    rr(ADDR_STAT, 8'h62, "status kept");
    pr(8'h5A, 8'hA5);
    rr(ADDR_RES_LO, 8'h5A, "low alone");
    @(negedge clock_in);
    irq = 1'b0;
    meas(16'h1234, 1'b0);
    rr(ADDR_RES_HI, 8'hA5, "latched high");
    pr(8'h34, 8'h12);
    rr(ADDR_STAT, 8'h02, "status valid only");
    @(negedge clock_in);
    en = 1'b0;
    cw(4);
    repeat (12) @(negedge link_clk_in);
    rr(ADDR_STAT, 8'h00, "valid after disable");
    $display("test meas done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_mismatch++;
    $display("FAIL %0t watchdog", $time);
    close_out();
  end
  initial begin
    repeat (6) @(negedge clock_in);
    rst_n_in = 1'b1;
    repeat (6) @(negedge link_clk_in);
    cw(12);
    t_reset();
    t_ident();
    t_ctrl();
    t_offset();
    t_meas();
    close_out();
  end
endmodule
